// File: design/pt_pkg.sv
// package: constants, states and helpers of the pulse train speed control block
package pt_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FREQ_W = 24;
  localparam int ACC_W = 28;
  localparam int MON_W = 16;
  localparam int ERR_W = 16;
  localparam int IRQ_W = 4;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TARGET = 8'h04;
  localparam logic [7:0] OFS_RATE = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_PULSES = 8'h10;
  localparam logic [7:0] OFS_MONITOR = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_PRESENT = 8'h1C;
  localparam logic [7:0] OFS_ERROR = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
  // field positions
  localparam int CTRL_MODE = 0;
  localparam int CTRL_DIR = 1;
  localparam int CTRL_SEARCH = 2;
  localparam int CTRL_NOPROX = 3;
  localparam int CMD_STEP = 0;
  localparam int CMD_RAMP = 1;
  localparam int CMD_STOP = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REV = 1;
  localparam int IRQ_TMO = 2;
  localparam int IRQ_REJ = 3;
  // error codes and reset values
  localparam logic [ERR_W-1:0] ERR_NONE = 16'h0000;
  localparam logic [ERR_W-1:0] ERR_REVERSE = 16'h0206;
  localparam logic [ERR_W-1:0] ERR_TIMEOUT = 16'h0300;
  localparam logic [MON_W-1:0] MONITOR_RST = 16'h0064;
  // timing
  localparam int CLK_HZ = 25_000_000;
  localparam int RAMP_TICK_US = 1000;
  localparam int RAMP_TICK_CYC = CLK_HZ / 1_000_000 * RAMP_TICK_US;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_SEARCH,
    ST_REVERSE,
    ST_SETTLE
  } st_t;
  // one ramp step from cur toward tgt, never overshooting
  function automatic logic [FREQ_W-1:0] step_toward(input logic [FREQ_W-1:0] cur,
      input logic [FREQ_W-1:0] tgt, input logic [FREQ_W-1:0] rate);
    if (cur < tgt) begin
      return ((tgt - cur) > rate) ? cur + rate : tgt;
    end
    return ((cur - tgt) > rate) ? cur - rate : tgt;
  endfunction : step_toward
endpackage : pt_pkg

// File: design/rate_gen_if.sv
// interface: sequencer to pulse rate generator
`timescale 1ns/1ns
`default_nettype none
interface rate_gen_if;
  logic run;
  logic [pt_pkg::FREQ_W-1:0] freq;
  logic pulse;
  logic edge_p;
  modport ctrl (output run, output freq, input pulse, input edge_p);
  modport gen (input run, input freq, output pulse, output edge_p);
endinterface : rate_gen_if
`default_nettype wire

// File: design/pulse_nco.sv
// module: phase accumulator that turns a frequency word into a pulse train
`timescale 1ns/1ns
`default_nettype none
module pulse_nco (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  // rate port
  rate_gen_if.gen gen
);
  localparam int MSB = pt_pkg::ACC_W - 1;
  logic [pt_pkg::ACC_W-1:0] acc_reg;
  logic msb_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= '0;
      msb_reg <= 1'b0;
    end else if (ce) begin
      if (gen.run) begin
        acc_reg <= acc_reg + pt_pkg::ACC_W'(gen.freq);
      end else begin
        acc_reg <= '0;
      end
      msb_reg <= gen.run & acc_reg[MSB];
    end
  end
  // pulse output straight from a flop
  assign gen.pulse = msb_reg;
  // rising edge of the coming pulse, one cycle ahead of it
  assign gen.edge_p = ce & gen.run & acc_reg[MSB] & ~msb_reg;
endmodule : pulse_nco
`default_nettype wire

// File: design/pulse_train_speed_control.sv
// top: pulse train generator with speed ramps, origin search and settle monitor
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module pulse_train_speed_control #(
  parameter int RAMP_TICK_CYC = pt_pkg::RAMP_TICK_CYC
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // register port
  input wire logic [pt_pkg::ADDR_W-1:0] addr,
  input wire logic [pt_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [pt_pkg::DATA_W-1:0] rdata,
  // drive pins
  output logic pulse_out,
  output logic dir_out,
  input wire logic limit_cw_in,
  input wire logic limit_ccw_in,
  input wire logic origin_prox_in,
  input wire logic origin_in,
  input wire logic inpos_in,
  // interrupt
  output logic irq
);
  localparam logic [31:0] TICK_LAST = 32'(RAMP_TICK_CYC - 1);
  function automatic logic hit(input logic [pt_pkg::ADDR_W-1:0] a,
      input logic [pt_pkg::ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction : hit
  logic rst_s1_reg, rst_s2_reg, rst_n;
  pt_pkg::st_t st_reg;
  logic mode_reg, dir_reg, search_reg, noprox_reg;
  logic [pt_pkg::FREQ_W-1:0] target_reg, rate_cfg_reg, rate_act_reg, present_reg, ramp_next;
  logic [31:0] pulses_reg, remain_reg, tick_cnt_reg;
  logic [pt_pkg::MON_W-1:0] monitor_reg, mon_cnt_reg;
  logic ramping_reg, drive_dir_reg;
  logic [pt_pkg::ERR_W-1:0] err_code_reg;
  logic [pt_pkg::IRQ_W-1:0] irq_stat_reg, irq_mask_reg, events;
  logic tick, running, wr_ctrl, step_cmd, ramp_cmd, stop_cmd;
  logic lim_s, ref_s, ev_rev, ev_tmo, ev_done, ev_rej;

  rate_gen_if gen_if ();
  pulse_nco u_nco (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .gen(gen_if)
  );

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  // decode and events
  assign wr_ctrl = wr & hit(addr, pt_pkg::OFS_CTRL);
  assign step_cmd = wr & hit(addr, pt_pkg::OFS_CMD) & wdata[pt_pkg::CMD_STEP];
  assign ramp_cmd = wr & hit(addr, pt_pkg::OFS_CMD) & wdata[pt_pkg::CMD_RAMP] & ~wdata[pt_pkg::CMD_STEP];
  assign stop_cmd = wr & hit(addr, pt_pkg::OFS_CMD) & wdata[pt_pkg::CMD_STOP];
  assign running = st_reg != pt_pkg::ST_IDLE;
  assign lim_s = drive_dir_reg ? limit_cw_in : limit_ccw_in;
  assign ref_s = noprox_reg ? origin_in : origin_prox_in;
  assign tick = tick_cnt_reg == TICK_LAST;
  assign ramp_next = pt_pkg::step_toward(present_reg, target_reg, rate_act_reg);
  assign ev_rev = st_reg == pt_pkg::ST_REVERSE && lim_s;
  assign ev_tmo = st_reg == pt_pkg::ST_SETTLE && !inpos_in && mon_cnt_reg >= monitor_reg;
  assign ev_done = st_reg == pt_pkg::ST_SETTLE && inpos_in;
  assign ev_rej = (wr_ctrl && running && wdata[pt_pkg::CTRL_DIR] != dir_reg)
    || (running && (mode_reg || st_reg != pt_pkg::ST_RUN) && (step_cmd || ramp_cmd));
  always_comb begin
    events = '0;
    events[pt_pkg::IRQ_DONE] = ev_done;
    events[pt_pkg::IRQ_REV] = ev_rev;
    events[pt_pkg::IRQ_TMO] = ev_tmo;
    events[pt_pkg::IRQ_REJ] = ev_rej;
  end

  assign gen_if.run = st_reg == pt_pkg::ST_RUN || st_reg == pt_pkg::ST_SEARCH
    || st_reg == pt_pkg::ST_REVERSE;
  assign gen_if.freq = present_reg;
  assign pulse_out = gen_if.pulse;
  assign dir_out = drive_dir_reg;

  // software registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= 1'b0;
      dir_reg <= 1'b0;
      search_reg <= 1'b0;
      noprox_reg <= 1'b0;
      target_reg <= '0;
      rate_cfg_reg <= '0;
      pulses_reg <= '0;
      monitor_reg <= pt_pkg::MONITOR_RST;
      irq_mask_reg <= '0;
    end else if (ce && wr) begin
      if (hit(addr, pt_pkg::OFS_CTRL) && !running) begin
        mode_reg <= wdata[pt_pkg::CTRL_MODE];
        dir_reg <= wdata[pt_pkg::CTRL_DIR];
        search_reg <= wdata[pt_pkg::CTRL_SEARCH];
        noprox_reg <= wdata[pt_pkg::CTRL_NOPROX];
      end
      if (hit(addr, pt_pkg::OFS_TARGET)) begin
        target_reg <= wdata[pt_pkg::FREQ_W-1:0];
      end
      if (hit(addr, pt_pkg::OFS_RATE)) begin
        rate_cfg_reg <= wdata[pt_pkg::FREQ_W-1:0];
      end
      if (hit(addr, pt_pkg::OFS_PULSES)) begin
        pulses_reg <= wdata;
      end
      if (hit(addr, pt_pkg::OFS_MONITOR)) begin
        monitor_reg <= wdata[pt_pkg::MON_W-1:0];
      end
      if (hit(addr, pt_pkg::OFS_IRQ_MASK)) begin
        irq_mask_reg <= wdata[pt_pkg::IRQ_W-1:0];
      end
    end
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= '0;
    end else if (ce) begin
      if (wr && hit(addr, pt_pkg::OFS_IRQ_STAT)) begin
        irq_stat_reg <= (irq_stat_reg & ~wdata[pt_pkg::IRQ_W-1:0]) | events;
      end else begin
        irq_stat_reg <= irq_stat_reg | events;
      end
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ramp and monitor time base
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= '0;
    end else if (ce) begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_cnt_reg <= '0;
    end else if (ce) begin
      if (st_reg != pt_pkg::ST_SETTLE) begin
        mon_cnt_reg <= '0;
      end else if (tick && mon_cnt_reg != '1) begin
        mon_cnt_reg <= mon_cnt_reg + 16'h1;
      end
    end
  end

  // sequencer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= pt_pkg::ST_IDLE;
      present_reg <= '0;
      rate_act_reg <= '0;
      remain_reg <= '0;
      ramping_reg <= 1'b0;
      drive_dir_reg <= 1'b0;
      err_code_reg <= pt_pkg::ERR_NONE;
    end else if (ce) begin
      unique case (st_reg)
        pt_pkg::ST_IDLE: begin
          if (step_cmd || ramp_cmd) begin
            err_code_reg <= pt_pkg::ERR_NONE;
            drive_dir_reg <= dir_reg;
            remain_reg <= pulses_reg;
            rate_act_reg <= rate_cfg_reg;
            ramping_reg <= ramp_cmd && !search_reg;
            if (search_reg) begin
              st_reg <= pt_pkg::ST_SEARCH;
              present_reg <= target_reg;
            end else if (mode_reg && pulses_reg == '0) begin
              st_reg <= pt_pkg::ST_SETTLE;
            end else begin
              st_reg <= pt_pkg::ST_RUN;
              present_reg <= ramp_cmd ? '0 : target_reg;
            end
          end
        end
        pt_pkg::ST_RUN: begin
          if (stop_cmd) begin
            st_reg <= pt_pkg::ST_IDLE;
            present_reg <= '0;
            ramping_reg <= 1'b0;
          end else if (step_cmd && !mode_reg) begin
            present_reg <= target_reg;
            ramping_reg <= 1'b0;
            if (target_reg == '0) begin
              st_reg <= pt_pkg::ST_IDLE;
            end
          end else if (ramp_cmd && !mode_reg) begin
            ramping_reg <= 1'b1;
            rate_act_reg <= rate_cfg_reg;
          end else if (mode_reg && gen_if.edge_p && remain_reg == 32'h1) begin
            st_reg <= pt_pkg::ST_SETTLE;
            present_reg <= '0;
            ramping_reg <= 1'b0;
          end else begin
            if (mode_reg && gen_if.edge_p) begin
              remain_reg <= remain_reg - 32'h1;
            end
            if (ramping_reg && tick) begin
              present_reg <= ramp_next;
              if (ramp_next == target_reg) begin
                ramping_reg <= 1'b0;
                if (target_reg == '0) begin
                  st_reg <= pt_pkg::ST_IDLE;
                end
              end
            end
          end
        end
        pt_pkg::ST_SEARCH: begin
          if (stop_cmd) begin
            st_reg <= pt_pkg::ST_IDLE;
            present_reg <= '0;
          end else if (ref_s) begin
            st_reg <= pt_pkg::ST_REVERSE;
          end else if (lim_s) begin
            drive_dir_reg <= !drive_dir_reg;
          end
        end
        pt_pkg::ST_REVERSE: begin
          if (ev_rev) begin
            st_reg <= pt_pkg::ST_IDLE;
            present_reg <= '0;
            err_code_reg <= pt_pkg::ERR_REVERSE;
          end else if (stop_cmd) begin
            st_reg <= pt_pkg::ST_IDLE;
            present_reg <= '0;
          end else if (!ref_s) begin
            st_reg <= pt_pkg::ST_SETTLE;
            present_reg <= '0;
          end
        end
        pt_pkg::ST_SETTLE: begin
          if (ev_tmo) begin
            st_reg <= pt_pkg::ST_IDLE;
            err_code_reg <= pt_pkg::ERR_TIMEOUT;
          end else if (ev_done || stop_cmd) begin
            st_reg <= pt_pkg::ST_IDLE;
          end
        end
        default: begin
          st_reg <= pt_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= '0;
      if (rd) begin
        case (addr)
          pt_pkg::OFS_CTRL: rdata <= {28'h0, noprox_reg, search_reg, dir_reg, mode_reg};
          pt_pkg::OFS_TARGET: rdata <= {8'h00, target_reg};
          pt_pkg::OFS_RATE: rdata <= {8'h00, rate_cfg_reg};
          pt_pkg::OFS_PULSES: rdata <= pulses_reg;
          pt_pkg::OFS_MONITOR: rdata <= {16'h0000, monitor_reg};
          pt_pkg::OFS_STATUS: rdata <= {28'h0, st_reg == pt_pkg::ST_SEARCH
            || st_reg == pt_pkg::ST_REVERSE, ramping_reg, drive_dir_reg, running};
          pt_pkg::OFS_PRESENT: rdata <= {8'h00, present_reg};
          pt_pkg::OFS_ERROR: rdata <= {16'h0000, err_code_reg};
          pt_pkg::OFS_IRQ_STAT: rdata <= {28'h0, irq_stat_reg};
          pt_pkg::OFS_IRQ_MASK: rdata <= {28'h0, irq_mask_reg};
          default: rdata <= '0;
        endcase
      end
    end
  end

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n || !ce);

  a_reverse_stop: assert property (ev_rev |=> st_reg == pt_pkg::ST_IDLE && err_code_reg == 16'h0206)
    else $error("limit during reversal did not stop with 0206");
  a_noprox_reverse: assert property (ev_rev && noprox_reg |=> irq_stat_reg[pt_pkg::IRQ_REV] && !gen_if.run)
    else $error("origin reversal limit not flagged");
  a_timeout_flag: assert property (ev_tmo |=> err_code_reg == 16'h0300 && irq_stat_reg[pt_pkg::IRQ_TMO])
    else $error("positioning timeout not flagged");
  a_timeout_local: assert property (ev_tmo |=> $stable(dir_out) && present_reg == '0)
    else $error("timeout disturbed the output");
  a_cont_holds: assert property (st_reg == pt_pkg::ST_RUN && !mode_reg && !wr && !(ramping_reg && tick)
    |=> st_reg == pt_pkg::ST_RUN)
    else $error("continuous output ended without cause");
  a_count_end: assert property (st_reg == pt_pkg::ST_RUN && mode_reg && gen_if.edge_p && remain_reg == 32'h1
    && !stop_cmd |=> st_reg == pt_pkg::ST_SETTLE ##1 !gen_if.pulse)
    else $error("pulse count did not end the run");
  a_step_start: assert property (st_reg == pt_pkg::ST_IDLE && step_cmd && !search_reg && !mode_reg
    |=> st_reg == pt_pkg::ST_RUN && present_reg == $past(target_reg))
    else $error("step start not at target");
  a_ramp_start: assert property (st_reg == pt_pkg::ST_IDLE && ramp_cmd && !search_reg && !mode_reg
    |=> present_reg == '0 && ramping_reg)
    else $error("ramp start wrong");
  a_step_change: assert property (st_reg == pt_pkg::ST_RUN && !mode_reg && step_cmd && !stop_cmd
    |=> present_reg == $past(target_reg) && !ramping_reg)
    else $error("step change not immediate");
  a_ramp_rise: assert property (st_reg == pt_pkg::ST_RUN && ramping_reg && tick && !wr
    && present_reg < target_reg |=> present_reg > $past(present_reg) && present_reg <= target_reg)
    else $error("ramp did not rise");
  a_ramp_fall: assert property (st_reg == pt_pkg::ST_RUN && ramping_reg && tick && !wr
    && present_reg > target_reg |=> present_reg < $past(present_reg) && present_reg >= target_reg)
    else $error("ramp did not fall");
  a_rate_take: assert property (st_reg == pt_pkg::ST_RUN && !mode_reg && ramp_cmd && !stop_cmd
    |=> rate_act_reg == $past(rate_cfg_reg))
    else $error("new rate not taken");
  a_dir_hold: assert property (st_reg == pt_pkg::ST_RUN ##1 st_reg == pt_pkg::ST_RUN |-> $stable(dir_out))
    else $error("direction changed while running");

  c_ramp_retarget: cover property (st_reg == pt_pkg::ST_RUN && ramping_reg && ramp_cmd);
  c_reverse_err: cover property (ev_rev);
  c_timeout: cover property (ev_tmo);
  c_count_done: cover property (ev_done);
endmodule : pulse_train_speed_control
`default_nettype wire

// File: verif/drive_model.sv
// drive model: counts pulses and answers with positioning completed
`timescale 1ns/1ns
`default_nettype none
module drive_model #(
  parameter int SETTLE_CYC = 20
) (
  // clock
  input wire logic sys_clk,
  // pulse and direction from the generator
  input wire logic pulse,
  input wire logic dir,
  // bench controls
  input wire logic answer_en,
  input wire logic count_clr,
  // responses
  output logic inpos,
  output logic last_dir,
  output int pulse_count
);
  logic pulse_d = 1'b0;
  int idle = 0;
  // counts rising edges and keeps the direction seen at each
  always_ff @(posedge sys_clk) begin
    pulse_d <= pulse;
    idle <= (pulse != pulse_d) ? 0 : ((idle < SETTLE_CYC) ? idle + 1 : idle);
    if (count_clr) begin
      pulse_count <= 0;
    end else if (pulse && !pulse_d) begin
      pulse_count <= pulse_count + 1;
      last_dir <= dir;
    end
  end
  // completion only once the pulses have stood still for a while
  assign inpos = answer_en && (idle >= SETTLE_CYC);
endmodule : drive_model
`default_nettype wire

// File: verif/pulse_train_speed_control_tb_top.sv
// testbench: register-level scenarios for the pulse train speed control block
`timescale 1ns/1ns
`default_nettype none
module pulse_train_speed_control_tb_top;
  localparam int TICK = 8;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [pt_pkg::ADDR_W-1:0] addr = 8'h00;
  logic [pt_pkg::DATA_W-1:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [pt_pkg::DATA_W-1:0] rdata;
  logic pulse_out;
  logic dir_out;
  logic irq;
  logic inpos;
  logic last_dir;
  logic limit_cw_in = 1'b0;
  logic limit_ccw_in = 1'b0;
  logic origin_prox_in = 1'b0;
  logic origin_in = 1'b0;
  logic answer_en = 1'b0;
  logic count_clr = 1'b1;
  int pulse_count;
  int n_errors = 0;
  int check_count = 0;
  int snap;
  logic [31:0] v;

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  pulse_train_speed_control #(.RAMP_TICK_CYC(TICK)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pulse_out(pulse_out), .dir_out(dir_out), .limit_cw_in(limit_cw_in),
    .limit_ccw_in(limit_ccw_in), .origin_prox_in(origin_prox_in), .origin_in(origin_in),
    .inpos_in(inpos), .irq(irq)
  );

  drive_model drive (
    .sys_clk(sys_clk), .pulse(pulse_out), .dir(dir_out), .answer_en(answer_en),
    .count_clr(count_clr), .inpos(inpos), .last_dir(last_dir), .pulse_count(pulse_count)
  );

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    check(name, d, exp);
  endtask : rd_chk

  task automatic in_range(input string name, input logic [31:0] x, input logic [31:0] lo, input logic [31:0] hi);
    check(name, {31'h0, (x > lo) && (x < hi)}, 32'h00000001);
  endtask : in_range

  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #(40 * 10000);
    n_errors++;
    wrap_up();
  end

  initial begin
    cyc(2);
    rstn <= 1'b1;
    count_clr <= 1'b0;
    cyc(3);
    rd_chk("monitor_rst", pt_pkg::OFS_MONITOR, 32'h00000064); // monitor default
    rd_chk("status_rst", pt_pkg::OFS_STATUS, 32'h00000000); // idle after reset
    rd_chk("error_rst", pt_pkg::OFS_ERROR, 32'h00000000); // no error code
    rd_chk("unmapped", 8'h40, 32'h00000000); // unmapped refused
    // continuous step start, free run, step change, refused reversal
    wr_reg(pt_pkg::OFS_TARGET, 32'h00800000);
    wr_reg(pt_pkg::OFS_CMD, 32'h00000001);
    rd_chk("present_step", pt_pkg::OFS_PRESENT, 32'h00800000); // start speed
    rd_chk("status_run", pt_pkg::OFS_STATUS, 32'h00000001); // running
    count_clr <= 1'b1;
    cyc(1);
    count_clr <= 1'b0;
    cyc(400);
    in_range("free_run_pulses", 32'(pulse_count), 32'h0000000A, 32'h0000000E); // no count
    rd_chk("still_running", pt_pkg::OFS_STATUS, 32'h00000001); // keeps running
    wr_reg(pt_pkg::OFS_TARGET, 32'h00200000);
    wr_reg(pt_pkg::OFS_CMD, 32'h00000001);
    rd_chk("present_jump", pt_pkg::OFS_PRESENT, 32'h00200000); // one step
    wr_reg(pt_pkg::OFS_CTRL, 32'h00000002);
    rd_chk("ctrl_kept", pt_pkg::OFS_CTRL, 32'h00000000); // write refused
    check("dir_kept", {31'h0, dir_out}, 32'h00000000); // direction held
    rd_chk("rej_flag", pt_pkg::OFS_IRQ_STAT, 32'h00000008); // refusal flagged
    wr_reg(pt_pkg::OFS_IRQ_STAT, 32'h00000008);
    rd_chk("rej_clear", pt_pkg::OFS_IRQ_STAT, 32'h00000000); // flag cleared
    wr_reg(pt_pkg::OFS_CMD, 32'h00000004);
    rd_chk("stopped", pt_pkg::OFS_STATUS, 32'h00000000); // ends on stop
    // ramps up, rate change mid-ramp, ramp down
    wr_reg(pt_pkg::OFS_RATE, 32'h00000010);
    wr_reg(pt_pkg::OFS_TARGET, 32'h00000100);
    wr_reg(pt_pkg::OFS_CMD, 32'h00000002);
    cyc(5 * TICK);
    rd_reg(pt_pkg::OFS_PRESENT, v);
    in_range("ramp_rising", v, 32'h00000000, 32'h00000100); // ramp up
    rd_reg(pt_pkg::OFS_STATUS, v);
    check("ramping", {31'h0, v[2]}, 32'h00000001); // ramping flag
    wr_reg(pt_pkg::OFS_RATE, 32'h00000080);
    wr_reg(pt_pkg::OFS_CMD, 32'h00000002);
    cyc(3 * TICK + 2);
    rd_chk("new_rate", pt_pkg::OFS_PRESENT, 32'h00000100); // new rate at once
    wr_reg(pt_pkg::OFS_RATE, 32'h00000010);
    wr_reg(pt_pkg::OFS_TARGET, 32'h00000040);
    wr_reg(pt_pkg::OFS_CMD, 32'h00000002);
    cyc(2 * TICK);
    rd_reg(pt_pkg::OFS_PRESENT, v);
    in_range("ramp_falling", v, 32'h00000040, 32'h00000100); // from present
    cyc(14 * TICK);
    rd_chk("ramp_low", pt_pkg::OFS_PRESENT, 32'h00000040); // falls to target
    wr_reg(pt_pkg::OFS_CMD, 32'h00000004);
    // independent run with completion answer
    wr_reg(pt_pkg::OFS_CTRL, 32'h00000001);
    wr_reg(pt_pkg::OFS_PULSES, 32'h00000005);
    wr_reg(pt_pkg::OFS_TARGET, 32'h00800000);
    count_clr <= 1'b1;
    answer_en <= 1'b1;
    cyc(1);
    count_clr <= 1'b0;
    wr_reg(pt_pkg::OFS_CMD, 32'h00000001);
    cyc(260);
    check("pulse_total", 32'(pulse_count), 32'h00000005); // programmed count
    rd_chk("done_flag", pt_pkg::OFS_IRQ_STAT, 32'h00000001); // completed
    wr_reg(pt_pkg::OFS_IRQ_STAT, 32'h00000001);
    // independent run with no answer: settle timeout
    answer_en <= 1'b0;
    wr_reg(pt_pkg::OFS_MONITOR, 32'h00000003);
    wr_reg(pt_pkg::OFS_IRQ_MASK, 32'h00000004);
    wr_reg(pt_pkg::OFS_PULSES, 32'h00000002);
    wr_reg(pt_pkg::OFS_CMD, 32'h00000001);
    cyc(60);
    rd_chk("error_early", pt_pkg::OFS_ERROR, 32'h00000000); // not before time
    cyc(80);
    check("irq_timeout", {31'h0, irq}, 32'h00000001); // unmasked event
    rd_chk("error_timeout", pt_pkg::OFS_ERROR, 32'h00000300); // timeout code
    rd_chk("status_timeout", pt_pkg::OFS_STATUS, 32'h00000000); // back to idle
    check("dir_timeout", {31'h0, dir_out}, 32'h00000000); // nothing else moves
    wr_reg(pt_pkg::OFS_IRQ_STAT, 32'h00000004);
    cyc(1);
    check("irq_cleared", {31'h0, irq}, 32'h00000000); // cleared by one
    // reversing search with proximity, then with origin only
    for (int k = 0; k < 2; k++) begin
      wr_reg(pt_pkg::OFS_CTRL, (k == 0) ? 32'h00000006 : 32'h0000000E);
      wr_reg(pt_pkg::OFS_CMD, 32'h00000001);
      cyc(20);
      rd_reg(pt_pkg::OFS_STATUS, v);
      check("searching", {31'h0, v[3]}, 32'h00000001); // search runs
      check("search_dir", {31'h0, last_dir}, 32'h00000001); // pulse plus direction
      if (k == 0) begin
        origin_prox_in <= 1'b1;
      end else begin
        origin_in <= 1'b1;
      end
      cyc(4);
      rd_chk("error_cleared", pt_pkg::OFS_ERROR, 32'h00000000); // not yet
      limit_cw_in <= 1'b1;
      cyc(3);
      rd_chk("error_reverse", pt_pkg::OFS_ERROR, 32'h00000206); // reverse code
      rd_reg(pt_pkg::OFS_STATUS, v);
      check("search_stop", {31'h0, v[0]}, 32'h00000000); // emergency stop
      rd_reg(pt_pkg::OFS_IRQ_STAT, v);
      check("rev_flag", {31'h0, v[1]}, 32'h00000001); // event flagged
      snap = pulse_count;
      cyc(64);
      check("no_more_pulses", 32'(pulse_count), 32'(snap)); // output halted
      limit_cw_in <= 1'b0;
      origin_prox_in <= 1'b0;
      origin_in <= 1'b0;
      wr_reg(pt_pkg::OFS_IRQ_STAT, 32'h0000000F);
    end
    wrap_up();
  end
endmodule : pulse_train_speed_control_tb_top
`default_nettype wire
